// ===== core/oep_cfg_pkg.sv
// constants, field layout and carrier types for the out endpoint configuration byte
package oep_cfg_pkg;
  // register map of the plain port
  localparam logic [2:0] ADDR_CFG      = 3'h0;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h1;
  localparam logic [2:0] ADDR_IRQ_EN   = 3'h2;
  localparam logic [2:0] ADDR_IRQ_CLR  = 3'h3;
  localparam logic [2:0] ADDR_COUNT    = 3'h4;
  // configuration byte fields
  localparam int BIT_EN     = 7;
  localparam int BIT_ISO    = 6;
  localparam int BIT_B5     = 5;
  localparam int BPS_W      = 5;
  localparam int CNT_W      = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // interrupt status bits
  localparam int IRQ_W      = 3;
  localparam int EV_RX      = 0;
  localparam int EV_OVF     = 1;
  localparam int EV_TOGERR  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  typedef struct packed {
    logic       endpoint_enable;
    logic       iso;
    logic       bit5;
    logic [4:0] low;
  } cfg_byte_t;

  // packet report from the buffer manager
  typedef struct packed {
    logic             valid;
    logic             data_toggle;
    logic             overflow;
    logic [CNT_W-1:0] byte_count;
  } rx_report_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } div_state_t;
endpackage

// ===== core/sample_divider.sv
// serial divider turning a received byte total into a sample count
`timescale 1ns/10ps
module sample_divider #(
  parameter int CNT_W = 7,
  parameter int BPS_W = 5
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  // request
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] bytes_i,
  input  wire logic [BPS_W-1:0] bps_code_i,
  // answer
  output logic                  done_o,
  output logic      [CNT_W-1:0] samples_o
);
  typedef struct packed {
    oep_cfg_pkg::div_state_t st;
    logic [CNT_W-1:0]        rem;
    logic [BPS_W:0]          div;
    logic [CNT_W-1:0]        quo;
    logic                    done;
  } st_t;
  st_t s_q, s_d;

  // repeated subtraction; done at most 130 cycles after start, cheaper than a real divider
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      oep_cfg_pkg::ST_IDLE: begin
        if (start_i) begin
          s_d.rem = bytes_i;
          s_d.div = {1'b0, bps_code_i} + 1'b1;
          s_d.quo = '0;
          s_d.st  = oep_cfg_pkg::ST_DIV;
        end
      end
      oep_cfg_pkg::ST_DIV: begin
        if ({1'b0, s_q.rem} >= {{(CNT_W-BPS_W){1'b0}}, s_q.div}) begin
          s_d.rem = s_q.rem - CNT_W'(s_q.div);
          s_d.quo = s_q.quo + 1'b1;
        end else begin
          s_d.st = oep_cfg_pkg::ST_DONE;
        end
      end
      oep_cfg_pkg::ST_DONE: begin
        s_d.done = 1'b1;
        s_d.st   = oep_cfg_pkg::ST_IDLE;
      end
      default: s_d.st = oep_cfg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o    = s_q.done;
  assign samples_o = s_q.quo;
endmodule

// ===== core/irq_bank.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/10ps
module irq_bank #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // events and software access
  input  wire logic [W-1:0] event_i,
  input  wire logic [W-1:0] clear_i,
  input  wire logic         en_we_i,
  input  wire logic [W-1:0] en_wdata_i,
  // state
  output logic      [W-1:0] status_o,
  output logic      [W-1:0] enable_o,
  output logic              irq_o
);
  typedef struct packed {
    logic [W-1:0] stat;
    logic [W-1:0] en;
  } st_t;
  st_t s_q, s_d;

  // a set in the same cycle as its clear wins
  always_comb begin
    s_d = s_q;
    s_d.stat = (s_q.stat & ~clear_i) | event_i;
    if (en_we_i) begin
      s_d.en = en_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status_o = s_q.stat;
  assign enable_o = s_q.en;
  assign irq_o    = |(s_q.stat & s_q.en);
endmodule

// ===== core/out_endpoint_config_byte.sv
// out endpoint configuration byte with buffer manager updates and sample count
`timescale 1ns/10ps
module out_endpoint_config_byte (
  // clock and reset
  input  wire logic                               ref_clk_i,
  input  wire logic                               rstn_i,
  // register port
  input  wire logic [2:0]                         addr_i,
  input  wire logic [7:0]                         wdata_i,
  input  wire logic                               we_i,
  input  wire logic                               re_i,
  output logic      [7:0]                         rdata_o,
  // buffer manager report
  input  wire oep_cfg_pkg::rx_report_t            rx_i,
  input  wire logic                               nack_pending_i,
  // decoded configuration
  output logic                                    endpoint_enable_o,
  output logic                                    iso_o,
  output logic                                    expected_toggle_o,
  output logic                                    overrun_flag_o,
  output logic      [oep_cfg_pkg::BPS_W-1:0]      frame_byte_size_field_o,
  output logic                                    accept_o,
  output logic      [oep_cfg_pkg::CNT_W-1:0]      received_count_field_o,
  output logic                                    count_valid_o,
  // interrupt
  output logic                                    irq_o
);
  typedef struct packed {
    oep_cfg_pkg::cfg_byte_t          cfg;
    logic [7:0]                      rdata;
    logic [oep_cfg_pkg::CNT_W-1:0]   count;
    logic                            cnt_vld;
  } st_t;
  st_t s_q, s_d;

  logic [oep_cfg_pkg::IRQ_W-1:0] ev;
  logic [oep_cfg_pkg::IRQ_W-1:0] irq_stat;
  logic [oep_cfg_pkg::IRQ_W-1:0] irq_en;
  logic                          div_done;
  logic [oep_cfg_pkg::CNT_W-1:0] div_samples;
  logic                          take;
  logic                          tog_ok;
  logic                          cfg_we;

  // address match, shared by every write strobe decode so the map lives in one place
  function automatic logic hit(input logic [2:0] a, input logic [2:0] sel);
    return a == sel;
  endfunction

  // a packet counts only while enabled; iso ignores no-acknowledge
  assign accept_o = s_q.cfg.endpoint_enable &
                    (s_q.cfg.iso | ~nack_pending_i);
  assign take     = rx_i.valid & accept_o;
  assign tog_ok   = rx_i.data_toggle == s_q.cfg.bit5;
  assign cfg_we   = we_i && hit(addr_i, oep_cfg_pkg::ADDR_CFG);

  // events: good packet, overflow, toggle mismatch
  always_comb begin
    ev = '0;
    ev[oep_cfg_pkg::EV_RX]     = take & (s_q.cfg.iso | tog_ok);
    ev[oep_cfg_pkg::EV_OVF]    = take & s_q.cfg.iso & rx_i.overflow;
    ev[oep_cfg_pkg::EV_TOGERR] = take & ~s_q.cfg.iso & ~tog_ok;
  end

  sample_divider #(
    .CNT_W(oep_cfg_pkg::CNT_W),
    .BPS_W(oep_cfg_pkg::BPS_W)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (take & s_q.cfg.iso),
    .bytes_i   (rx_i.byte_count),
    .bps_code_i(s_q.cfg.low),
    .done_o    (div_done),
    .samples_o (div_samples)
  );

  irq_bank #(
    .W(oep_cfg_pkg::IRQ_W)
  ) u_irq (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .event_i   (ev),
    .clear_i   ((we_i && hit(addr_i, oep_cfg_pkg::ADDR_IRQ_CLR)) ?
                wdata_i[oep_cfg_pkg::IRQ_W-1:0] : '0),
    .en_we_i   (we_i && hit(addr_i, oep_cfg_pkg::ADDR_IRQ_EN)),
    .en_wdata_i(wdata_i[oep_cfg_pkg::IRQ_W-1:0]),
    .status_o  (irq_stat),
    .enable_o  (irq_en),
    .irq_o     (irq_o)
  );

  // next state of the shared byte; layout chosen by the iso bit
  always_comb begin
    s_d = s_q;
    s_d.cnt_vld = 1'b0;
    if (cfg_we) begin
      s_d.cfg = wdata_i;
    end
    if (s_q.cfg.iso) begin
      // overflow is sticky; hardware set wins over a zero write
      if (ev[oep_cfg_pkg::EV_OVF]) begin
        s_d.cfg.bit5 = 1'b1;
      end
    end else if (ev[oep_cfg_pkg::EV_RX]) begin
      // flip expected toggle; a same-cycle write loses to hardware
      s_d.cfg.bit5 = ~s_q.cfg.bit5;
    end
    // byte count direct, iso count via divider
    if (take && !s_q.cfg.iso && tog_ok) begin
      s_d.count   = rx_i.byte_count;
      s_d.cnt_vld = 1'b1;
    end else if (div_done) begin
      s_d.count   = div_samples;
      s_d.cnt_vld = 1'b1;
    end
    // read data, one cycle after the strobe
    s_d.rdata = 8'h00;
    if (re_i) begin
      case (addr_i)
        oep_cfg_pkg::ADDR_CFG:      s_d.rdata = s_q.cfg;
        oep_cfg_pkg::ADDR_IRQ_STAT: s_d.rdata = 8'(irq_stat);
        oep_cfg_pkg::ADDR_IRQ_EN:   s_d.rdata = 8'(irq_en);
        oep_cfg_pkg::ADDR_COUNT:    s_d.rdata = {1'b0, s_q.count};
        default:                    s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q.cfg     <= oep_cfg_pkg::CFG_RESET;
      s_q.rdata   <= 8'h00;
      s_q.count   <= '0;
      s_q.cnt_vld <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // decoded views of the byte
  assign rdata_o                 = s_q.rdata;
  assign endpoint_enable_o       = s_q.cfg.endpoint_enable;
  assign iso_o                   = s_q.cfg.iso;
  assign expected_toggle_o       = ~s_q.cfg.iso & s_q.cfg.bit5;
  assign overrun_flag_o          = s_q.cfg.iso & s_q.cfg.bit5;
  assign frame_byte_size_field_o = s_q.cfg.iso ? s_q.cfg.low : '0;
  assign received_count_field_o  = s_q.count;
  assign count_valid_o           = s_q.cnt_vld;
endmodule

// ===== verification/bm_model.sv
// buffer manager model that issues packet reports to the endpoint byte
`timescale 1ns/10ps
module bm_model (
  // clock
  input  wire logic              ref_clk_i,
  // packet report and no-acknowledge level
  output oep_cfg_pkg::rx_report_t rx_o,
  output logic                   nack_o
);
  // idle until the bench asks for a packet
  initial begin
    rx_o   = '0;
    nack_o = 1'b0;
  end

  // one-cycle report; fields turn over afterwards so stale data is never reused
  task automatic send(input logic nk, tg, ov, input logic [6:0] c);
    @(posedge ref_clk_i);
    rx_o   <= {1'b1, tg, ov, c};
    nack_o <= nk;
    @(posedge ref_clk_i);
    rx_o   <= {1'b0, ~tg, ~ov, ~c};
  endtask
endmodule

// ===== verification/out_endpoint_config_byte_sva.sv
// port assertions for the out endpoint configuration byte
`timescale 1ns/10ps
module cfg_byte_chk (
  // clock, reset and register port
  input wire logic                    ref_clk_i,
  input wire logic                    rstn_i,
  input wire logic [2:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    we_i,
  input wire logic                    re_i,
  input wire logic [7:0]              rdata_o,
  // packet side and decoded fields
  input wire oep_cfg_pkg::rx_report_t rx_i,
  input wire logic                    nack_pending_i,
  input wire logic                    endpoint_enable_o,
  input wire logic                    iso_o,
  input wire logic                    expected_toggle_o,
  input wire logic                    overrun_flag_o,
  input wire logic [4:0]              frame_byte_size_field_o,
  input wire logic                    accept_o,
  input wire logic [6:0]              received_count_field_o,
  input wire logic                    count_valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic pkt;
  logic cfg_wr;
  // a taken packet and a firmware write to the byte
  assign pkt    = rx_i.valid && accept_o;
  assign cfg_wr = we_i && addr_i == 3'h0;

  property p_wr; cfg_wr |=> {endpoint_enable_o, iso_o} == $past(wdata_i[7:6]); endproperty
  a_wr: assert property (p_wr) else $error("enable or type not written");
  property p_acc; accept_o == (endpoint_enable_o && (iso_o || !nack_pending_i)); endproperty
  a_acc: assert property (p_acc) else $error("accept wrong");
  property p_tog;
    pkt && !iso_o && !we_i && rx_i.data_toggle == expected_toggle_o
      |=> expected_toggle_o != $past(expected_toggle_o);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle did not flip");
  property p_ovf; pkt && iso_o && rx_i.overflow && !we_i |=> overrun_flag_o; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not set");
  property p_hold; overrun_flag_o && !cfg_wr |=> overrun_flag_o; endproperty
  a_hold: assert property (p_hold) else $error("overflow lost");
  property p_lay;
    iso_o ? !expected_toggle_o : !overrun_flag_o && frame_byte_size_field_o == 5'h0;
  endproperty
  a_lay: assert property (p_lay) else $error("layout wrong");
  property p_rd;
    re_i && addr_i == 3'h0 && iso_o |=> rdata_o ==
      $past({endpoint_enable_o, iso_o, overrun_flag_o, frame_byte_size_field_o});
  endproperty
  a_rd: assert property (p_rd) else $error("byte read wrong");
  property p_cnt;
    pkt && !iso_o && rx_i.data_toggle == expected_toggle_o
      |=> count_valid_o && received_count_field_o == $past(rx_i.byte_count);
  endproperty
  a_cnt: assert property (p_cnt) else $error("byte count wrong");
  property p_iso; pkt && iso_o |-> ##[1:132] count_valid_o; endproperty
  a_iso: assert property (p_iso) else $error("sample count missing");
endmodule

bind out_endpoint_config_byte cfg_byte_chk u_chk (.ref_clk_i, .rstn_i, .addr_i, .wdata_i,
  .we_i, .re_i, .rdata_o, .rx_i, .nack_pending_i, .endpoint_enable_o, .iso_o,
  .expected_toggle_o, .overrun_flag_o, .frame_byte_size_field_o, .accept_o,
  .received_count_field_o, .count_valid_o);

// ===== verification/out_endpoint_config_byte_test.sv
// self-checking bench for the out endpoint configuration byte
`timescale 1ns/10ps
module out_endpoint_config_byte_test;
  logic                    ref_clk_i, rstn_i, we_i, re_i, re_d, nack_pending_i;
  logic [2:0]              addr_i;
  logic [7:0]              wdata_i, rdata_o;
  oep_cfg_pkg::rx_report_t rx_i;
  logic                    endpoint_enable_o, iso_o, expected_toggle_o, overrun_flag_o;
  logic                    accept_o, count_valid_o, irq_o;
  logic [4:0]              frame_byte_size_field_o;
  logic [6:0]              received_count_field_o;
  logic [8:0]              q_rd[$];
  logic [6:0]              q_cnt[$];
  logic [4:0]              codes[3] = '{5'h03, 5'h00, 5'h1f};
  int                      mismatches, n_tests, seed, c;

  out_endpoint_config_byte dut (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i,
    .rdata_o, .rx_i, .nack_pending_i, .endpoint_enable_o, .iso_o, .expected_toggle_o,
    .overrun_flag_o, .frame_byte_size_field_o, .accept_o, .received_count_field_o,
    .count_valid_o, .irq_o);
  bm_model bm (.ref_clk_i, .rx_o(rx_i), .nack_o(nack_pending_i));

  // free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_rd(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [6:0] got, exp);
    chk_rd({2'b0, got}, {2'b0, exp});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge ref_clk_i);
    we_i    <= 1'b0;
  endtask
  // expected read is interrupt level over the data byte
  task automatic rd(input logic [2:0] a, input logic [8:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    q_rd.push_back(e);
    @(posedge ref_clk_i);
    re_i   <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // answers are compared with the oldest note; an answer nobody expected fails
  always @(posedge ref_clk_i) begin
    re_d <= re_i;
    if (re_d) begin
      chk_rd({irq_o, rdata_o}, q_rd.size() ? q_rd.pop_front() : 9'hx);
    end
    if (count_valid_o) begin
      chk_cnt(received_count_field_o, q_cnt.size() ? q_cnt.pop_front() : 7'hx);
    end
  end

  // watchdog well past the longest path through the tests
  initial begin
    #50us;
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    {rstn_i, we_i, re_i, addr_i, wdata_i} = '0;
    {mismatches, n_tests} = '0;
    seed = 32'h0bb1;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 8; a++) if (a != 3) rd(a[2:0], 9'h000);
    $display("reset test done");
    wr(3'h0, 8'h80);
    rd(3'h0, 9'h080);
    c = $random(seed) & 32'h7f;
    q_cnt.push_back(c[6:0]);
    bm.send(1'b0, 1'b0, 1'b0, c[6:0]);
    rd(3'h0, 9'h0a0);
    rd(3'h4, {2'b00, c[6:0]});
    bm.send(1'b0, 1'b0, 1'b0, 7'h05);
    rd(3'h0, 9'h0a0);
    wr(3'h2, 8'h04);
    rd(3'h1, 9'h105);
    wr(3'h1, 8'h07);
    wr(3'h3, 8'h05);
    rd(3'h1, 9'h000);
    bm.send(1'b1, 1'b1, 1'b0, 7'h09);
    rd(3'h0, 9'h0a0);
    $display("non-iso test done");
    // long waits leave room for the serial divider of the largest count
    for (int i = 0; i < 3; i++) begin
      // firmware side: each code stands for a whole multichannel frame
      wr(3'h0, {3'b110, codes[i]});
      c = $random(seed) & 32'h7f;
      q_cnt.push_back(7'(c / (codes[i] + 1)));
      bm.send(1'b1, 1'b0, 1'b1, c[6:0]);
      repeat (140) @(posedge ref_clk_i);
      rd(3'h0, {1'b0, 3'b111, codes[i]});
      rd(3'h4, {2'b00, 7'(c / (codes[i] + 1))});
      q_cnt.push_back(7'(c / (codes[i] + 1)));
      bm.send(1'b1, 1'b0, 1'b0, c[6:0]);
      repeat (140) @(posedge ref_clk_i);
      rd(3'h0, {1'b0, 3'b111, codes[i]});
    end
    rd(3'h1, 9'h003);
    wr(3'h0, 8'hc0);
    rd(3'h0, 9'h0c0);
    $display("iso test done");
    wr(3'h0, 8'h40);
    bm.send(1'b1, 1'b0, 1'b1, 7'h7f);
    repeat (140) @(posedge ref_clk_i);
    rd(3'h0, 9'h040);
    repeat (4) @(posedge ref_clk_i);
    chk_cnt(7'(q_cnt.size() + q_rd.size()), 7'h00);
    $display("disable test done");
    conclude();
  end
endmodule
